// ===== rtl/tmr_map.svh
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH
// Register indices, byte address is four times the index
`define TMR_I_CTRL    8'hC8
`define TMR_I_RLL     8'hCA
`define TMR_I_RLH     8'hCB
`define TMR_I_CNTL    8'hCC
`define TMR_I_CNTH    8'hCD
`define TMR_I_CHOICE  8'hD0
`define TMR_I_STS     8'hD1
`define TMR_I_MASK    8'hD2
// Control field positions
`define TMR_B_FH      7
`define TMR_B_FL      6
`define TMR_B_LEN     5
`define TMR_B_CAP     4
`define TMR_B_SPLIT   3
`define TMR_B_RUN     2
`define TMR_B_SEL_HI  1
`define TMR_B_SEL_LO  0
// Clock choice field positions
`define TMR_B_CHL     0
`define TMR_B_CHH     1
// Status and mask field positions
`define TMR_B_SH      0
`define TMR_B_SL      1
`define TMR_B_SC      2
// Reset values
`define TMR_RST_BYTE  8'h00
`define TMR_RST_CNT   16'h0000
// Divider counts
`define TMR_DIV_SYS   12
`define TMR_DIV_RTC   8
`endif

// ===== rtl/tmr_pkg.sv
package tmr_pkg;
    typedef logic [9:0] tmr_addr_type;
    typedef enum logic [1:0] {
        TMR_SEL_SYS_RTC   = 2'b00,
        TMR_SEL_SYS_RTC_B = 2'b01,
        TMR_SEL_SYS_CMP   = 2'b10,
        TMR_SEL_RTC_CMP   = 2'b11
    } tmr_sel_type;
endpackage : tmr_pkg

// ===== rtl/tmr_timer2.sv
// Operation
// - Low-byte overflow interrupts only with low enable and low mask bit set.
// - With both enables set, each low-byte overflow raises the interrupt.
// - Capture enable set puts the timer into capture mode.
// - Split bit set gives two 8-bit reload counters, clear gives one 16-bit.
// - Run bit enables counting; clear halts the whole timer in 16-bit mode.
// - In split mode run gates only high byte; low byte always counts.
// - Select field picks alternate clock and trigger; shared by both bytes.
// - Alternate clock and trigger inputs are synchronised before use.
// - Codes 00/01 sys/12 with rtc/8 trigger; 10 comparator; 11 rtc/8 clock.
// - Reload low byte is read/write and resets to zero.
// - Capture copies the 16-bit count into reload bytes and sets high flag.
// - Overflow flags are set by hardware and cleared only by software.
// - In 16-bit mode the high flag sets on wrap from all ones.
// - In split mode each byte reloads from its own reload byte.
`timescale 1ns/1ps
`include "tmr_map.svh"
module tmr_timer2 #(
    parameter int SYS_DIV = `TMR_DIV_SYS,
    parameter int RTC_DIV = `TMR_DIV_RTC
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire tmr_pkg::tmr_addr_type paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  rtc_clk_in,
    input  wire logic                  cmp0_in,
    output logic                       irq
);
    import tmr_pkg::*;

    localparam int SW = $clog2(SYS_DIV);
    localparam int RW = $clog2(RTC_DIV);

    logic [SW-1:0] sys_cnt, next_sys_cnt;
    logic [RW-1:0] rtc_cnt, next_rtc_cnt;
    logic [2:0]    rtc_sync, cmp_sync;
    logic          sys12_tick, rtc8_tick, rtc_edge, cmp_edge;
    logic          ext_tick, trig, tick_l, tick_h;
    tmr_sel_type   sel;
    logic [15:0]   cnt, next_cnt;
    logic [7:0]    ctrl, next_ctrl, rl, next_rl, rh, next_rh;
    logic [1:0]    choice, next_choice;
    logic [2:0]    sts, next_sts, mask, next_mask, clr;
    logic          ev_h, ev_l, ev_c, next_irq;
    logic          access, done, wr_en, hit;
    logic [7:0]    rdata;
    logic [31:0]   next_prdata;
    logic          next_pready, next_pslverr;

    // Address decode against one register index
    function automatic logic reg_is(input tmr_addr_type a, input logic [7:0] idx);
        reg_is = (a[1:0] == 2'h0) && (a[9:2] == idx);
    endfunction : reg_is

    ////////////////////////////////////////////////////////////////////////////
    // Clock sources and triggers

    // Edge and divider terms, read from second and third stages only
    // synchronised sources
    assign rtc_edge   = rtc_sync[1] & ~rtc_sync[2];
    assign cmp_edge   = cmp_sync[1] & ~cmp_sync[2];
    assign sys12_tick = (sys_cnt == SW'(SYS_DIV - 1));
    assign rtc8_tick  = rtc_edge && (rtc_cnt == RW'(RTC_DIV - 1));
    assign sel        = tmr_sel_type'(ctrl[`TMR_B_SEL_HI:`TMR_B_SEL_LO]);

    // Source selection by code
    // select decode
    always_comb begin
        ext_tick = (sel == TMR_SEL_RTC_CMP) ? rtc8_tick : sys12_tick;
        trig     = (sel == TMR_SEL_SYS_CMP || sel == TMR_SEL_RTC_CMP) ? cmp_edge : rtc8_tick;
    end

    // Per-byte choice between system clock and alternate clock
    // shared alternate clock
    assign tick_l = choice[`TMR_B_CHL] | ext_tick;
    assign tick_h = choice[`TMR_B_CHH] | ext_tick;

    // Divider next values
    always_comb begin
        next_sys_cnt = sys12_tick ? '0 : sys_cnt + 1'b1;
        next_rtc_cnt = rtc_cnt;
        if (rtc_edge) begin
            next_rtc_cnt = rtc8_tick ? '0 : rtc_cnt + 1'b1;
        end
    end

    // Synchronisers and dividers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rtc_sync <= 3'h0;
            cmp_sync <= 3'h0;
            sys_cnt  <= '0;
            rtc_cnt  <= '0;
        end else begin
            rtc_sync <= {rtc_sync[1:0], rtc_clk_in};
            cmp_sync <= {cmp_sync[1:0], cmp0_in};
            sys_cnt  <= next_sys_cnt;
            rtc_cnt  <= next_rtc_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter, reload and control

    assign access = psel & penable;
    assign done   = access & pready;
    assign wr_en  = done & pwrite & hit;

    // Counting, reload, capture, bus writes, flag sets
    always_comb begin
        next_cnt    = cnt;
        next_rl     = rl;
        next_rh     = rh;
        next_ctrl   = ctrl;
        next_choice = choice;
        ev_h        = 1'b0;
        ev_l        = 1'b0;
        ev_c        = 1'b0;
        if (!ctrl[`TMR_B_SPLIT]) begin
            if (ctrl[`TMR_B_RUN] && tick_l) begin
                ev_l = (cnt[7:0] == 8'hFF);
                if (cnt == 16'hFFFF) begin
                    ev_h = 1'b1;
                    next_cnt = ctrl[`TMR_B_CAP] ? `TMR_RST_CNT : {rh, rl};
                end else begin
                    next_cnt = cnt + 16'h0001;
                end
            end
        end else begin
            if (tick_l) begin
                ev_l = (cnt[7:0] == 8'hFF);
                next_cnt[7:0] = ev_l ? rl : cnt[7:0] + 8'h01;
            end
            if (ctrl[`TMR_B_RUN] && tick_h) begin
                ev_h = (cnt[15:8] == 8'hFF);
                next_cnt[15:8] = ev_h ? rh : cnt[15:8] + 8'h01;
            end
        end
        if (ctrl[`TMR_B_CAP] && trig) begin
            ev_c    = 1'b1;
            ev_h    = 1'b1;
            next_rl = cnt[7:0];
            next_rh = cnt[15:8];
        end
        // Software writes take priority over hardware updates, except the flag sets below
        if (wr_en) begin
            if (reg_is(paddr, `TMR_I_CTRL))   next_ctrl   = pwdata[7:0];
            if (reg_is(paddr, `TMR_I_RLL))    next_rl     = pwdata[7:0];
            if (reg_is(paddr, `TMR_I_RLH))    next_rh     = pwdata[7:0];
            if (reg_is(paddr, `TMR_I_CNTL))   next_cnt[7:0]  = pwdata[7:0];
            if (reg_is(paddr, `TMR_I_CNTH))   next_cnt[15:8] = pwdata[7:0];
            if (reg_is(paddr, `TMR_I_CHOICE)) next_choice = pwdata[1:0];
        end
        // hardware only sets flags, set wins
        next_ctrl[`TMR_B_FH] = next_ctrl[`TMR_B_FH] | ev_h;
        next_ctrl[`TMR_B_FL] = next_ctrl[`TMR_B_FL] | ev_l;
    end

    // Counter state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt    <= `TMR_RST_CNT;
            rl     <= `TMR_RST_BYTE;
            rh     <= `TMR_RST_BYTE;
            ctrl   <= `TMR_RST_BYTE;
            choice <= 2'h0;
        end else begin
            cnt    <= next_cnt;
            rl     <= next_rl;
            rh     <= next_rh;
            ctrl   <= next_ctrl;
            choice <= next_choice;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status, mask and output

    // Read clears only the bits that were returned
    always_comb begin
        clr       = (done && !pwrite && reg_is(paddr, `TMR_I_STS)) ? prdata[2:0] : 3'h0;
        next_sts  = (sts & ~clr) | {ev_c, ev_l, ev_h};
        next_mask = mask;
        if (wr_en && reg_is(paddr, `TMR_I_MASK)) begin
            next_mask = pwdata[2:0];
        end
        // low source needs low enable and mask
        next_irq = |(sts & mask & {1'b1, ctrl[`TMR_B_LEN], 1'b1});
    end

    // Interrupt registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sts  <= 3'h0;
            mask <= 3'h0;
            irq  <= 1'b0;
        end else begin
            sts  <= next_sts;
            mask <= next_mask;
            irq  <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave

    // Read mux and decode
    always_comb begin
        hit   = 1'b1;
        rdata = 8'h00;
        if (reg_is(paddr, `TMR_I_CTRL))        rdata = ctrl;
        else if (reg_is(paddr, `TMR_I_RLL))    rdata = rl;
        else if (reg_is(paddr, `TMR_I_RLH))    rdata = rh;
        else if (reg_is(paddr, `TMR_I_CNTL))   rdata = cnt[7:0];
        else if (reg_is(paddr, `TMR_I_CNTH))   rdata = cnt[15:8];
        else if (reg_is(paddr, `TMR_I_CHOICE)) rdata = {6'h00, choice};
        else if (reg_is(paddr, `TMR_I_STS))    rdata = {5'h00, sts};
        else if (reg_is(paddr, `TMR_I_MASK))   rdata = {5'h00, mask};
        else hit = 1'b0;
    end

    // One wait state, answer on second access cycle
    always_comb begin
        next_pready  = access & ~pready;
        next_pslverr = access & ~pready & ~hit;
        next_prdata  = prdata;
        if (access && !pready) begin
            next_prdata = {24'h000000, rdata};
        end
    end

    // Bus answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= next_pready;
            pslverr <= next_pslverr;
            prdata  <= next_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking chk_clk @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_low_irq_gate: assert property (
        sts[`TMR_B_SL] && mask[`TMR_B_SL] && ctrl[`TMR_B_LEN] |=> irq)
        else $error("low overflow interrupt not raised");

    chk_low_flag_set: assert property (
        ev_l |=> sts[`TMR_B_SL] && ctrl[`TMR_B_FL])
        else $error("low overflow flag or status missing");

    chk_capture_copy: assert property (
        ctrl[`TMR_B_CAP] && trig && !wr_en
        |=> {rh, rl} == $past(cnt) && ctrl[`TMR_B_FH])
        else $error("capture did not copy count");

    chk_split_low_free: assert property (
        ctrl[`TMR_B_SPLIT] && tick_l && cnt[7:0] != 8'hFF && !wr_en
        |=> cnt[7:0] == 8'($past(cnt[7:0]) + 8'h01))
        else $error("split low byte did not count");

    chk_halt_sixteen: assert property (
        !ctrl[`TMR_B_SPLIT] && !ctrl[`TMR_B_RUN] && !wr_en |=> $stable(cnt))
        else $error("halted timer moved");

    chk_wrap_reload: assert property (
        !ctrl[`TMR_B_SPLIT] && ctrl[`TMR_B_RUN] && tick_l && cnt == 16'hFFFF
        && !ctrl[`TMR_B_CAP] && !wr_en
        |=> cnt == {$past(rh), $past(rl)} && ctrl[`TMR_B_FH])
        else $error("16-bit reload or high flag wrong");

    chk_split_reload: assert property (
        ctrl[`TMR_B_SPLIT] && tick_l && cnt[7:0] == 8'hFF && !wr_en
        |=> cnt[7:0] == $past(rl))
        else $error("split low byte did not reload");

    chk_cmp_once: assert property (
        cmp_edge |=> !cmp_edge)
        else $error("comparator edge held two cycles");

    chk_rtc_div: assert property (
        rtc8_tick |=> !rtc8_tick [*8])
        else $error("rtc divider ticked twice");

    chk_bus_answer: assert property (
        access && !pready |=> pready ##1 !pready)
        else $error("bus answer not one cycle");

    cov_capture:    cover property (ctrl[`TMR_B_CAP] && trig);
    cov_split_high: cover property (ctrl[`TMR_B_SPLIT] && ev_h);
    cov_irq:        cover property (!irq ##1 irq);

endmodule : tmr_timer2

// ===== testbench/tmr_timer2_bench.sv
`timescale 1ns/1ps
`include "tmr_map.svh"
`define CHECK(got, exp) begin compares++; if ((got) !== (exp)) begin fail_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module tmr_timer2_bench;
    import tmr_pkg::*;
    logic              pclk;
    logic              presetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    tmr_addr_type      paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              rtc_clk_in;
    logic              cmp0_in;
    logic              irq;
    logic [2:0]        rtc_div;
    logic [31:0]       lfsr;
    logic [65:0]       exp_q[$];
    logic [65:0]       note;
    int                fail_count;
    int                compares;
    int                cycles;

    ////////////////////////////////////////////////////////////////////////////
    tmr_timer2 #(.SYS_DIV(12), .RTC_DIV(8)) DUT (
        .pclk       (pclk),
        .presetn    (presetn),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pwdata     (pwdata),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .rtc_clk_in (rtc_clk_in),
        .cmp0_in    (cmp0_in),
        .irq        (irq)
    );

    // Bus clock, 8 ns period
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Slow clock, eight bus cycles a period
    always @(posedge pclk) begin
        rtc_div    <= rtc_div + 3'h1;
        rtc_clk_in <= rtc_div[2];
    end

    // Hang guard
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            finish_test();
        end
    end

    // Read result watcher, oldest note first
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            `CHECK({pslverr, prdata} & note[65:33], note[32:0])
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction : lfsr_next

    // One APB transfer, held until pready
    task apb(input logic wr_en, input logic [7:0] idx, input logic [7:0] data);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr_en;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h000000, data};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] idx, input logic [7:0] data);
        apb(1'b1, idx, data);
    endtask : wr

    // Read with a noted expectation, upper bits always zero
    task rd(input logic [7:0] idx, input logic err, input logic [7:0] val,
            input logic [7:0] msk);
        exp_q.push_back({1'b1, 24'hFFFFFF, msk, err, 24'h000000, val & msk});
        apb(1'b0, idx, 8'h00);
    endtask : rd

    task finish_test;
        if (fail_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h00000000;
        cmp0_in = 1'b0;
        rtc_clk_in = 1'b0;
        rtc_div = 3'h0;
        lfsr = 32'hEF4B;
        fail_count = 0;
        compares = 0;
        cycles = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, unmapped place, random read back
        rd(`TMR_I_CTRL, 1'b0, 8'h00, 8'hFF);
        rd(`TMR_I_RLL, 1'b0, `TMR_RST_BYTE, 8'hFF);
        rd(`TMR_I_RLH, 1'b0, `TMR_RST_BYTE, 8'hFF);
        rd(8'hC9, 1'b1, 8'h00, 8'hFF);
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            wr(`TMR_I_RLL, lfsr[7:0]);
            wr(`TMR_I_RLH, lfsr[15:8]);
            rd(`TMR_I_RLL, 1'b0, lfsr[7:0], 8'hFF);
            rd(`TMR_I_RLH, 1'b0, lfsr[15:8], 8'hFF);
        end
        // Every select code drives the 16-bit counter through a wrap
        wr(`TMR_I_CHOICE, 8'h00);
        for (int code = 0; code < 4; code++) begin
            wr(`TMR_I_CNTL, 8'hFF);
            wr(`TMR_I_CNTH, 8'hFF);
            wr(`TMR_I_CTRL, 8'h04 | code[7:0]);
            repeat ((code == 3) ? 80 : 16) @(posedge pclk);
            rd(`TMR_I_CTRL, 1'b0, 8'hC4 | code[7:0], 8'hFF);
            wr(`TMR_I_CTRL, 8'h00);
        end
        // Split mode: low byte free, high byte gated, low interrupt enable
        apb(1'b0, `TMR_I_STS, 8'h00);
        wr(`TMR_I_CHOICE, 8'h03);
        wr(`TMR_I_RLL, 8'h80);
        wr(`TMR_I_RLH, 8'h40);
        wr(`TMR_I_CNTH, 8'hFF);
        wr(`TMR_I_CNTL, 8'hFF);
        wr(`TMR_I_MASK, 8'h02);
        wr(`TMR_I_CTRL, 8'h08);
        repeat (10) @(posedge pclk);
        rd(`TMR_I_CTRL, 1'b0, 8'h48, 8'hFF);
        rd(`TMR_I_CNTH, 1'b0, 8'hFF, 8'hFF);
        `CHECK(irq, 1'b0)
        rd(`TMR_I_STS, 1'b0, 8'h02, 8'hFF);
        wr(`TMR_I_CTRL, 8'h28);
        repeat (2) @(posedge pclk);
        `CHECK(irq, 1'b0)
        repeat (140) @(posedge pclk);
        `CHECK(irq, 1'b1)
        rd(`TMR_I_CTRL, 1'b0, 8'h68, 8'hFF);
        wr(`TMR_I_CTRL, 8'h0C);
        repeat (6) @(posedge pclk);
        rd(`TMR_I_CTRL, 1'b0, 8'h8C, 8'hBF);
        // 16-bit wrap reloads both bytes, high event masked then unmasked
        wr(`TMR_I_CTRL, 8'h00);
        wr(`TMR_I_CHOICE, 8'h01);
        wr(`TMR_I_RLH, 8'hAB);
        wr(`TMR_I_RLL, 8'h00);
        apb(1'b0, `TMR_I_STS, 8'h00);
        wr(`TMR_I_CNTH, 8'hFF);
        wr(`TMR_I_CNTL, 8'hF0);
        wr(`TMR_I_CTRL, 8'h04);
        repeat (30) @(posedge pclk);
        rd(`TMR_I_CTRL, 1'b0, 8'hC4, 8'hFF);
        wr(`TMR_I_CTRL, 8'h00);
        rd(`TMR_I_CNTH, 1'b0, 8'hAB, 8'hFF);
        `CHECK(irq, 1'b0)
        wr(`TMR_I_MASK, 8'h01);
        repeat (2) @(posedge pclk);
        `CHECK(irq, 1'b1)
        rd(`TMR_I_STS, 1'b0, 8'h03, 8'hFF);
        repeat (2) @(posedge pclk);
        `CHECK(irq, 1'b0)
        wr(`TMR_I_CNTL, 8'h77);
        repeat (30) @(posedge pclk);
        rd(`TMR_I_CNTL, 1'b0, 8'h77, 8'hFF);
        // Capture on comparator rising edge, one capture per edge
        wr(`TMR_I_CNTH, 8'h12);
        wr(`TMR_I_CNTL, 8'h34);
        wr(`TMR_I_CTRL, 8'h12);
        apb(1'b0, `TMR_I_STS, 8'h00);
        cmp0_in <= 1'b1;
        repeat (6) @(posedge pclk);
        rd(`TMR_I_RLL, 1'b0, 8'h34, 8'hFF);
        rd(`TMR_I_RLH, 1'b0, 8'h12, 8'hFF);
        rd(`TMR_I_CTRL, 1'b0, 8'h92, 8'hFF);
        rd(`TMR_I_STS, 1'b0, 8'h05, 8'hFF);
        wr(`TMR_I_CNTL, 8'h55);
        wr(`TMR_I_CTRL, 8'h12);
        repeat (6) @(posedge pclk);
        rd(`TMR_I_RLL, 1'b0, 8'h34, 8'hFF);
        rd(`TMR_I_CTRL, 1'b0, 8'h12, 8'hFF);
        cmp0_in <= 1'b0;
        repeat (6) @(posedge pclk);
        cmp0_in <= 1'b1;
        repeat (6) @(posedge pclk);
        rd(`TMR_I_RLL, 1'b0, 8'h55, 8'hFF);
        // Capture on the divided slow clock under select code 00
        wr(`TMR_I_CNTL, 8'h66);
        wr(`TMR_I_CTRL, 8'h10);
        repeat (80) @(posedge pclk);
        rd(`TMR_I_RLL, 1'b0, 8'h66, 8'hFF);
        rd(`TMR_I_CTRL, 1'b0, 8'h90, 8'hFF);
        finish_test();
    end
endmodule : tmr_timer2_bench
